// file: adc_timing_pkg.sv
package adc_timing_pkg;
  // port address map
  localparam logic [6:0] SUPPLY_SENSOR_OFFSET_COEF = 7'h08;
  localparam logic [6:0] CONVERTER_OFFSET_COEF = 7'h09;
  localparam logic [6:0] CONVERTER_GAIN_COEF = 7'h0A;
  localparam logic [6:0] STATUS_LAST = 7'h3F;
  localparam logic [6:0] CONFIG0 = 7'h40;
  localparam logic [6:0] CONFIG1 = 7'h41;
  localparam logic [6:0] CONFIG2 = 7'h42;
  localparam logic [6:0] SEQ_SELECT_LO = 7'h48;
  localparam logic [6:0] SEQ_SELECT_HI = 7'h49;
  localparam logic [6:0] SEQ_ACQ_LO = 7'h4E;
  localparam logic [6:0] SEQ_ACQ_HI = 7'h4F;
  // config0 fields
  localparam int CHAN_LSB = 0;
  localparam int EXTRA_ACQ_BIT = 8;
  localparam int EVENT_MODE_BIT = 9;
  localparam int AVG_LSB = 12;
  // config1 fields
  localparam int CAL_ENABLE_BIT = 5;
  localparam int SEQ_MODE_LSB = 12;
  // config2 field
  localparam int DIV_LSB = 8;
  // reset values
  localparam logic [15:0] CONFIG0_RESET = 16'h0000;
  localparam logic [15:0] CONFIG1_RESET = 16'h0000;
  localparam logic [15:0] CONFIG2_RESET = 16'h0200;
  localparam logic [7:0] DIV_MIN = 8'h02;
  // calibration channel
  localparam logic [4:0] CAL_CHANNEL = 5'h08;
  // timing counts
  localparam int ACQ_TICKS = 4;
  localparam int EXTRA_ACQ_TICKS = 6;
  localparam int CONV_TICKS = 22;
  localparam int RESULT_DELAY = 10;
  localparam int PORT_LATENCY = 3;
  localparam int RESYNC_CYCLES = 20;
  // gain field
  localparam int GAIN_SIGN_BIT = 5;
  localparam logic [15:0] GAIN_SCALE = 16'h03E8;
  typedef enum {ACQUIRE, SAMPLE, CONVERT, WAIT_TRIGGER} phase_type;
endpackage : adc_timing_pkg

// file: adc_conversion_timing.sv
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_timing
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic portClockRunning,
  input wire logic portEnable,
  input wire logic portWriteEnable,
  input wire logic [6:0] portAddress,
  input wire logic [15:0] portDataIn,
  output logic [15:0] portDataOut,
  output logic portReady,
  input wire logic conversionTrigger,
  input wire logic [9:0] rawCode,
  input wire logic [9:0] measSupplyOffset,
  input wire logic [9:0] measConverterOffset,
  input wire logic [5:0] measGainCorrection,
  output logic busy,
  output logic endOfConversion,
  output logic endOfSequence,
  output logic [4:0] channel
);

  ////////////////////////////////////////////////////////////////////////////
  // reset release and declarations
  localparam int PORT_LATENCY_W = adc_timing_pkg::PORT_LATENCY;
  logic rstMeta;
  logic rstSync;
  logic [15:0] cfg0Pend, cfg1Pend, cfg2Pend;
  logic [15:0] cfg0, cfg1, cfg2;
  logic cfgDirty;
  logic [31:0] seqSelect, seqAcqExt;
  logic [9:0] supplyOffsetCoef, converterOffsetCoef;
  logic [5:0] gainCoef;
  logic [15:0] statusMem [0:31];
  adc_timing_pkg::phase_type phase;
  logic [12:0] phaseCount;
  logic [4:0] convChannel;
  logic [9:0] sampledCode;
  logic [3:0] postCount;
  logic resultPending;
  logic [4:0] resultChannel;
  logic [9:0] resultCode;
  logic resultLast;
  logic [17:0] avgSum;
  logic [8:0] avgCount;
  logic [4:0] resyncCount;
  logic [PORT_LATENCY_W-1:0] portPipe;
  logic [6:0] portAddrHeld;
  logic portWriteHeld;
  logic [15:0] portDataHeld;
  logic trigPrev;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rstMeta <= 1'b0;
      rstSync <= 1'b0;
    end
    else
    begin
      rstMeta <= 1'b1;
      rstSync <= rstMeta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // helper functions
  function automatic logic [7:0] divRatio(input logic [15:0] c2);
    logic [7:0] d;
    d = c2[adc_timing_pkg::DIV_LSB +: 8];
    divRatio = (d < adc_timing_pkg::DIV_MIN) ? adc_timing_pkg::DIV_MIN : d;
  endfunction : divRatio

  // first set channel above cur, wrapping; flags last of sequence
  function automatic logic [5:0] nextSeqChannel(input logic [31:0] sel,
                                                input logic [4:0] cur);
    logic [4:0] idx;
    logic found;
    nextSeqChannel = {1'b0, cur};
    found = 1'b0;
    for (int i = 1; i <= 32; i++)
    begin
      idx = 5'(cur + 5'(i));
      if (!found && sel[idx])
      begin
        found = 1'b1;
        nextSeqChannel = {(idx <= cur), idx};
      end
    end
  endfunction : nextSeqChannel

  // offset removal then slope correction
  function automatic logic [9:0] calibrate(input logic [9:0] raw,
                                           input logic [9:0] off,
                                           input logic [5:0] gain);
    logic signed [12:0] sum;
    logic [22:0] scaled;
    logic signed [23:0] adj;
    sum = $signed({3'b000, raw}) + $signed({{3{off[9]}}, off});
    if (sum < 0)
      sum = '0;
    scaled = 23'(sum[11:0] * gain[4:0]) / 23'(adc_timing_pkg::GAIN_SCALE);
    adj = gain[adc_timing_pkg::GAIN_SIGN_BIT] ? 24'(sum) + 24'(scaled)
                                             : 24'(sum) - 24'(scaled);
    if (adj < 0)
      calibrate = 10'h000;
    else if (adj > 24'sh0003FF)
      calibrate = 10'h3FF;
    else
      calibrate = adj[9:0];
  endfunction : calibrate

  ////////////////////////////////////////////////////////////////////////////
  // port clock resynchronisation window
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      resyncCount <= 5'(adc_timing_pkg::RESYNC_CYCLES);
    else if (!rstSync || !portClockRunning)
      resyncCount <= 5'(adc_timing_pkg::RESYNC_CYCLES);
    else if (resyncCount != 5'h00)
      resyncCount <= resyncCount - 5'h01;
  end

  ////////////////////////////////////////////////////////////////////////////
  // port access: latch on enable, answer three cycles later
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      portPipe <= '0;
      portAddrHeld <= 7'h00;
      portWriteHeld <= 1'b0;
      portDataHeld <= 16'h0000;
    end
    else
    begin
      portPipe <= {portPipe[PORT_LATENCY_W-2:0],
                   portEnable && resyncCount == 5'h00 && rstSync};
      if (portEnable)
      begin
        portAddrHeld <= portAddress;
        portWriteHeld <= portWriteEnable;
        portDataHeld <= portDataIn;
      end
    end
  end

  assign portReady = portPipe[PORT_LATENCY_W-1];

  // read data mux, registered at the answer
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      portDataOut <= 16'h0000;
    else if (portPipe[PORT_LATENCY_W-2] && !portWriteHeld)
    begin
      case (portAddrHeld)
        adc_timing_pkg::SUPPLY_SENSOR_OFFSET_COEF: portDataOut <= {supplyOffsetCoef, 6'h00};
        adc_timing_pkg::CONVERTER_OFFSET_COEF: portDataOut <= {converterOffsetCoef, 6'h00};
        adc_timing_pkg::CONVERTER_GAIN_COEF: portDataOut <= {10'h000, gainCoef};
        adc_timing_pkg::CONFIG0: portDataOut <= cfg0Pend;
        adc_timing_pkg::CONFIG1: portDataOut <= cfg1Pend;
        adc_timing_pkg::CONFIG2: portDataOut <= cfg2Pend;
        adc_timing_pkg::SEQ_SELECT_LO: portDataOut <= seqSelect[15:0];
        adc_timing_pkg::SEQ_SELECT_HI: portDataOut <= seqSelect[31:16];
        adc_timing_pkg::SEQ_ACQ_LO: portDataOut <= seqAcqExt[15:0];
        adc_timing_pkg::SEQ_ACQ_HI: portDataOut <= seqAcqExt[31:16];
        default:
          portDataOut <= (portAddrHeld < 7'h20) ? statusMem[portAddrHeld[4:0]] : 16'h0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration: written copy, acted-on copy
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cfg0Pend <= adc_timing_pkg::CONFIG0_RESET;
      cfg1Pend <= adc_timing_pkg::CONFIG1_RESET;
      cfg2Pend <= adc_timing_pkg::CONFIG2_RESET;
      seqSelect <= 32'h0000_0000;
      seqAcqExt <= 32'h0000_0000;
    end
    else if (portPipe[PORT_LATENCY_W-2] && portWriteHeld)
    begin
      // status words, coefficients among them, take no writes
      case (portAddrHeld)
        adc_timing_pkg::CONFIG0: cfg0Pend <= portDataHeld;
        adc_timing_pkg::CONFIG1: cfg1Pend <= portDataHeld;
        adc_timing_pkg::CONFIG2: cfg2Pend <= portDataHeld;
        adc_timing_pkg::SEQ_SELECT_LO: seqSelect[15:0] <= portDataHeld;
        adc_timing_pkg::SEQ_SELECT_HI: seqSelect[31:16] <= portDataHeld;
        adc_timing_pkg::SEQ_ACQ_LO: seqAcqExt[15:0] <= portDataHeld;
        adc_timing_pkg::SEQ_ACQ_HI: seqAcqExt[31:16] <= portDataHeld;
        default: ;
      endcase
    end
  end

  // acted-on copy follows at once unless averaging holds it until the pulse
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cfg0 <= adc_timing_pkg::CONFIG0_RESET;
      cfg1 <= adc_timing_pkg::CONFIG1_RESET;
      cfg2 <= adc_timing_pkg::CONFIG2_RESET;
    end
    else if (cfg0[adc_timing_pkg::AVG_LSB +: 2] == 2'b00 || endOfConversion)
    begin
      cfg0 <= cfg0Pend;
      cfg1 <= cfg1Pend;
      cfg2 <= cfg2Pend;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // conversion sequencing, counted in port clocks
  logic seqMode;
  logic extendAcq;
  logic [12:0] acqLen, convLen;
  logic [5:0] seqNext;
  assign seqMode = cfg1[adc_timing_pkg::SEQ_MODE_LSB +: 4] != 4'h0;
  assign extendAcq = seqMode ? seqAcqExt[convChannel]
                             : cfg0[adc_timing_pkg::EXTRA_ACQ_BIT];
  assign acqLen = 13'(divRatio(cfg2) * (extendAcq ? adc_timing_pkg::ACQ_TICKS +
                  adc_timing_pkg::EXTRA_ACQ_TICKS : adc_timing_pkg::ACQ_TICKS));
  assign convLen = 13'(divRatio(cfg2) * adc_timing_pkg::CONV_TICKS);
  assign seqNext = nextSeqChannel(seqSelect, convChannel);

  // runs regardless of port clock status
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      phase <= adc_timing_pkg::ACQUIRE;
      phaseCount <= 13'h0000;
      convChannel <= 5'h00;
      sampledCode <= 10'h000;
      trigPrev <= 1'b0;
    end
    else if (!rstSync)
    begin
      phase <= adc_timing_pkg::ACQUIRE;
      phaseCount <= 13'h0000;
    end
    else
    begin
      trigPrev <= conversionTrigger;
      phaseCount <= phaseCount + 13'h0001;
      case (phase)
        adc_timing_pkg::ACQUIRE:
        begin
          if (!seqMode)
            convChannel <= cfg0[adc_timing_pkg::CHAN_LSB +: 5];
          if (phaseCount + 13'h0001 >= acqLen)
            phase <= adc_timing_pkg::SAMPLE;
        end
        adc_timing_pkg::SAMPLE:
        begin
          sampledCode <= rawCode;
          phaseCount <= 13'h0000;
          phase <= adc_timing_pkg::CONVERT;
        end
        adc_timing_pkg::CONVERT:
        begin
          if (phaseCount + 13'h0001 >= convLen)
          begin
            phaseCount <= 13'h0000;
            if (seqMode)
              convChannel <= seqNext[4:0];
            if (cfg0[adc_timing_pkg::EVENT_MODE_BIT] && !seqMode)
              phase <= adc_timing_pkg::WAIT_TRIGGER;
            else
              phase <= adc_timing_pkg::ACQUIRE;
          end
        end
        adc_timing_pkg::WAIT_TRIGGER:
        begin
          phaseCount <= 13'h0000;
          if (!seqMode)
            convChannel <= cfg0[adc_timing_pkg::CHAN_LSB +: 5];
          if (conversionTrigger && !trigPrev)
            phase <= adc_timing_pkg::SAMPLE;
        end
        default: phase <= adc_timing_pkg::ACQUIRE;
      endcase
    end
  end

  assign busy = phase == adc_timing_pkg::CONVERT;

  ////////////////////////////////////////////////////////////////////////////
  // busy fall: channel index, averaging, delayed transfer
  logic convDone;
  logic [8:0] avgTarget;
  logic [17:0] avgNew;
  assign convDone = busy && phaseCount + 13'h0001 >= convLen;
  assign avgTarget = cfg0[adc_timing_pkg::AVG_LSB +: 2] == 2'b01 ? 9'h010 :
                     cfg0[adc_timing_pkg::AVG_LSB +: 2] == 2'b10 ? 9'h040 :
                     cfg0[adc_timing_pkg::AVG_LSB +: 2] == 2'b11 ? 9'h100 : 9'h001;
  assign avgNew = avgSum + 18'(sampledCode);

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      channel <= 5'h00;
      avgSum <= 18'h00000;
      avgCount <= 9'h000;
      resultPending <= 1'b0;
      postCount <= 4'h0;
      resultChannel <= 5'h00;
      resultCode <= 10'h000;
      resultLast <= 1'b0;
    end
    else
    begin
      if (convDone)
      begin
        channel <= convChannel;
        if (avgCount + 9'h001 >= avgTarget || convChannel == adc_timing_pkg::CAL_CHANNEL)
        begin
          avgSum <= 18'h00000;
          avgCount <= 9'h000;
          resultPending <= 1'b1;
          postCount <= 4'h0;
          resultChannel <= convChannel;
          resultCode <= 10'(avgNew / 18'(avgTarget));
          resultLast <= seqMode && seqNext[5];
        end
        else
        begin
          avgSum <= avgNew;
          avgCount <= avgCount + 9'h001;
        end
      end
      else if (resultPending)
      begin
        postCount <= postCount + 4'h1;
        if (postCount == 4'(adc_timing_pkg::RESULT_DELAY - 1))
          resultPending <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // result transfer and end pulses
  logic transfer;
  assign transfer = resultPending && !convDone
                    && postCount == 4'(adc_timing_pkg::RESULT_DELAY - 1);

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      endOfConversion <= 1'b0;
      endOfSequence <= 1'b0;
    end
    else
    begin
      endOfConversion <= transfer;
      endOfSequence <= transfer && resultLast;
    end
  end

  // status words; calibration channel refreshes coefficients only
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      supplyOffsetCoef <= 10'h000;
      converterOffsetCoef <= 10'h000;
      gainCoef <= 6'h00;
      for (int i = 0; i < 32; i++)
        statusMem[i] <= 16'h0000;
    end
    else if (transfer)
    begin
      if (resultChannel == adc_timing_pkg::CAL_CHANNEL)
      begin
        supplyOffsetCoef <= 10'(-measSupplyOffset);
        converterOffsetCoef <= 10'(-measConverterOffset);
        gainCoef <= measGainCorrection;
      end
      else if (cfg1[adc_timing_pkg::CAL_ENABLE_BIT])
        statusMem[resultChannel] <= {calibrate(resultCode, converterOffsetCoef, gainCoef),
                                     6'h00};
      else
        statusMem[resultChannel] <= {resultCode, 6'h00};
    end
  end

endmodule : adc_conversion_timing
`default_nettype wire

// file: adc_conversion_timing_checker.sv
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_timing_checker
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic portEnable,
  input wire logic portReady,
  input wire logic busy,
  input wire logic endOfConversion,
  input wire logic endOfSequence,
  input wire logic [4:0] channel
);
  logic [15:0] busyCount;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // length of the current busy run
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      busyCount <= 16'h0000;
    else
      busyCount <= busy ? busyCount + 16'h0001 : 16'h0000;
  end
  ////////////////////////////////////////////////////////////
  // nine low cycles before the next sampling edge
  sequence acqGap;
    (!busy)[*8] ##1 !busy;
  endsequence
  // busy fell exactly ten cycles back
  sequence fellTenBack;
    $past(busy, 11) && !$past(busy, 10);
  endsequence
  chk_eoc_after_fall: assert property (endOfConversion |-> fellTenBack)
    else $error("end pulse not ten cycles after busy fell");
  chk_eoc_one_cycle: assert property (endOfConversion |=> !endOfConversion)
    else $error("end pulse longer than one cycle");
  chk_eos_with_eoc: assert property (endOfSequence |-> endOfConversion)
    else $error("sequence end without end pulse");
  chk_ready_latency: assert property (portReady |-> $past(portEnable, 3))
    else $error("ready without enable three cycles back");
  chk_ready_one_cycle: assert property (portReady |=> !portReady)
    else $error("ready longer than one cycle");
  chk_channel_on_fall: assert property (!$stable(channel) |-> $fell(busy))
    else $error("channel changed without busy falling");
  chk_busy_length: assert property ($fell(busy) |->
    (busyCount % 16'h0016 == 16'h0000) && (busyCount > 16'h002B))
    else $error("busy run not a whole number of converter clocks");
  chk_acq_gap: assert property ($fell(busy) |-> acqGap)
    else $error("acquisition shorter than four converter clocks");
endmodule : adc_conversion_timing_checker
`default_nettype wire

// file: port_fabric_model.sv
`timescale 1ns/1ps
`default_nettype none
module port_fabric_model
(
  input wire logic clk,
  input wire logic captureMode,
  input wire logic portReady,
  input wire logic [15:0] portDataOut,
  input wire logic endOfConversion,
  input wire logic [4:0] channel,
  output logic portEnable,
  output logic portWriteEnable,
  output logic [6:0] portAddress,
  output logic [15:0] portDataIn
);
  logic enReg = 1'b0;
  logic weReg = 1'b0;
  logic [6:0] addrReg = 7'h00;
  logic [15:0] dataReg = 16'h0000;
  // capture mode lets the end pulse fetch the converted channel
  always_comb
  begin
    portEnable = captureMode ? endOfConversion : enReg;
    portWriteEnable = captureMode ? 1'b0 : weReg;
    portAddress = captureMode ? {2'b00, channel} : addrReg;
    portDataIn = dataReg;
  end
  ////////////////////////////////////////////////////////////
  // one access: single enable cycle, released lines show garbage
  task automatic access(input logic w, input logic [6:0] a, input logic [15:0] d,
    output logic got, output logic [15:0] rd);
    int n;
    got = 1'b0;
    rd = 16'h0000;
    @(posedge clk);
    enReg <= 1'b1;
    weReg <= w;
    addrReg <= a;
    dataReg <= d;
    @(posedge clk);
    enReg <= 1'b0;
    // qualifiers held until the answer edge, then released
    for (n = 0; n < 6 && !got; n++)
    begin
      @(posedge clk);
      got = (portReady === 1'b1);
      rd = portDataOut;
    end
    weReg <= ~w;
    addrReg <= ~a;
    dataReg <= ~d;
  endtask : access
endmodule : port_fabric_model
`default_nettype wire

// file: test_adc_conversion_timing.sv
`timescale 1ns/1ps
`default_nettype none
module test_adc_conversion_timing;
  typedef struct {logic [15:0] mask; logic [15:0] val;} note_type;
  logic clk, arst_n, portClockRunning, conversionTrigger, captureMode;
  logic portEnable, portWriteEnable, portReady, busy, endOfConversion, endOfSequence;
  logic [6:0] portAddress;
  logic [15:0] portDataIn, portDataOut, rd;
  logic [9:0] rawCode, measSupplyOffset, measConverterOffset, raw, off, negOff, cal;
  logic [5:0] measGainCorrection;
  logic [4:0] channel, ch;
  logic got;
  note_type notes[$];
  note_type seen;
  int mismatches, checked, lo, hi, i, falls;
  adc_conversion_timing i_adc_conversion_timing (.clk(clk), .arst_n(arst_n),
    .portClockRunning(portClockRunning), .portEnable(portEnable),
    .portWriteEnable(portWriteEnable), .portAddress(portAddress), .portDataIn(portDataIn),
    .portDataOut(portDataOut), .portReady(portReady), .conversionTrigger(conversionTrigger),
    .rawCode(rawCode), .measSupplyOffset(measSupplyOffset),
    .measConverterOffset(measConverterOffset), .measGainCorrection(measGainCorrection),
    .busy(busy), .endOfConversion(endOfConversion), .endOfSequence(endOfSequence),
    .channel(channel));
  port_fabric_model i_port_fabric_model (.clk(clk), .captureMode(captureMode),
    .portReady(portReady), .portDataOut(portDataOut), .endOfConversion(endOfConversion),
    .channel(channel), .portEnable(portEnable), .portWriteEnable(portWriteEnable),
    .portAddress(portAddress), .portDataIn(portDataIn));
  // free running clock
  always #10 clk = ~clk;
  ////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [15:0] s, input logic [15:0] e);
    checked++;
    if (s !== e)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, s);
    end
  endtask : check
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : stop_test
  // 0 busy fall, 1 end pulse, 2 busy rise
  task automatic waitSig(input int which, input int limit);
    logic pb;
    pb = busy;
    for (int n = 0; n < limit; n++)
    begin
      @(negedge clk);
      if (which == 0 && pb === 1'b1 && busy === 1'b0) return;
      if (which == 1 && endOfConversion === 1'b1) return;
      if (which == 2 && pb === 1'b0 && busy === 1'b1) return;
      pb = busy;
    end
    check("event wait", 16'h0000, 16'h0001);
    stop_test();
  endtask : waitSig
  task automatic xfer(input logic w, input logic [6:0] a, input logic [15:0] d,
    input logic [15:0] m);
    notes.push_back('{w ? 16'h0000 : m, d});
    i_port_fabric_model.access(w, a, d, got, rd);
    check("port answer", {15'h0000, got}, 16'h0001);
  endtask : xfer
  task automatic waitChan(input logic [4:0] c);
    for (int n = 0; n < 6 && channel !== c; n++)
      waitSig(1, 2000);
    check("converted channel", {11'h000, channel}, {11'h000, c});
  endtask : waitChan
  // low and high run of one conversion, ending where busy falls
  task automatic measure(input logic fresh);
    lo = 0;
    hi = 0;
    if (fresh)
      waitSig(0, 2000);
    while (busy !== 1'b1 && lo < 2000)
    begin
      lo++;
      @(negedge clk);
    end
    while (busy === 1'b1 && hi < 2000)
    begin
      hi++;
      @(negedge clk);
    end
    ch = channel;
  endtask : measure
  task automatic timing(input int loExp, input int hiExp);
    measure(1'b1);
    measure(1'b0);
    check("acquire cycles", 16'(lo), 16'(loExp));
    check("convert cycles", 16'(hi), 16'(hiExp));
  endtask : timing
  // oldest note is compared against each answer
  always @(negedge clk)
  begin
    if (portReady === 1'b1 && notes.size() == 0)
      check("spare ready", 16'h0001, 16'h0000);
    else if (portReady === 1'b1)
    begin
      seen = notes.pop_front();
      check("read data", portDataOut & seen.mask, seen.val & seen.mask);
    end
  end
  ////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    arst_n = 1'b0;
    portClockRunning = 1'b1;
    conversionTrigger = 1'b0;
    captureMode = 1'b0;
    void'($urandom(32'hD28E));
    raw = 10'h100 + 10'($urandom_range(255, 0));
    off = 10'($urandom_range(15, 1));
    negOff = 10'h000 - off;
    // offset removed, then positive 1.0 percent slope correction
    lo = int'(raw - off);
    cal = 10'(lo + lo * 10 / 1000);
    rawCode = raw;
    measSupplyOffset = 10'h005;
    measConverterOffset = off;
    measGainCorrection = 6'h2A;
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    repeat (25) @(posedge clk);
    xfer(0, adc_timing_pkg::CONFIG2, adc_timing_pkg::CONFIG2_RESET, 16'hFFFF);
    xfer(0, adc_timing_pkg::CONFIG0, adc_timing_pkg::CONFIG0_RESET, 16'hFFFF);
    xfer(0, 7'h7F, 16'h0000, 16'hFFFF);
    timing(9, 44);
    // calibration, then coefficient words and their protection
    xfer(1, adc_timing_pkg::CONFIG0, {11'h000, adc_timing_pkg::CAL_CHANNEL}, 16'h0000);
    waitChan(adc_timing_pkg::CAL_CHANNEL);
    xfer(0, adc_timing_pkg::SUPPLY_SENSOR_OFFSET_COEF, 16'hFEC0, 16'hFFC0);
    xfer(0, adc_timing_pkg::CONVERTER_OFFSET_COEF, {negOff, 6'h00}, 16'hFFC0);
    xfer(0, adc_timing_pkg::CONVERTER_GAIN_COEF, 16'h002A, 16'hFFFF);
    xfer(1, adc_timing_pkg::CONVERTER_GAIN_COEF, 16'hFFFF, 16'h0000);
    xfer(0, adc_timing_pkg::CONVERTER_GAIN_COEF, 16'h002A, 16'hFFFF);
    // plain and corrected results, then capture by the end pulse
    xfer(1, adc_timing_pkg::CONFIG0, 16'h0003, 16'h0000);
    waitChan(5'h03);
    xfer(0, 7'h03, {raw, 6'h00}, 16'hFFC0);
    xfer(1, adc_timing_pkg::CONFIG1, 16'h0020, 16'h0000);
    waitSig(1, 2000);
    waitSig(1, 2000);
    xfer(0, 7'h03, {cal, 6'h00}, 16'hFFC0);
    notes.push_back('{16'hFFC0, {cal, 6'h00}});
    @(posedge clk);
    captureMode <= 1'b1;
    waitSig(1, 2000);
    repeat (6) @(posedge clk);
    captureMode <= 1'b0;
    // extended acquisition and a slower converter clock
    xfer(1, adc_timing_pkg::CONFIG0, 16'h0103, 16'h0000);
    timing(21, 44);
    xfer(1, adc_timing_pkg::CONFIG0, 16'h0003, 16'h0000);
    xfer(1, adc_timing_pkg::CONFIG2, 16'h0400, 16'h0000);
    timing(17, 88);
    xfer(1, adc_timing_pkg::CONFIG2, adc_timing_pkg::CONFIG2_RESET, 16'h0000);
    // clock loss keeps converting, port refused until resynced
    @(posedge clk);
    portClockRunning <= 1'b0;
    waitSig(1, 200);
    @(posedge clk);
    portClockRunning <= 1'b1;
    i_port_fabric_model.access(1'b0, adc_timing_pkg::CONFIG0, 16'h0000, got, rd);
    check("refused access", {15'h0000, got}, 16'h0000);
    repeat (20) @(posedge clk);
    xfer(0, adc_timing_pkg::CONFIG0, 16'h0003, 16'hFFFF);
    // event mode waits for the trigger
    xfer(1, adc_timing_pkg::CONFIG0, 16'h0203, 16'h0000);
    repeat (60) @(negedge clk);
    falls = 0;
    repeat (100) @(negedge clk) falls += int'(busy === 1'b1);
    check("busy without trigger", 16'(falls), 16'h0000);
    @(posedge clk);
    conversionTrigger <= 1'b1;
    waitSig(2, 10);
    @(posedge clk);
    conversionTrigger <= 1'b0;
    waitSig(1, 200);
    xfer(1, adc_timing_pkg::CONFIG0, 16'h0003, 16'h0000);
    @(posedge clk);
    conversionTrigger <= 1'b1;
    @(posedge clk);
    conversionTrigger <= 1'b0;
    // sequencer over channels 1, 3 and 5, channel 3 extended
    xfer(1, adc_timing_pkg::SEQ_SELECT_LO, 16'h002A, 16'h0000);
    xfer(1, adc_timing_pkg::SEQ_ACQ_LO, 16'h0008, 16'h0000);
    xfer(1, adc_timing_pkg::CONFIG1, 16'h1020, 16'h0000);
    measure(1'b1);
    for (i = 0; i < 6; i++)
    begin
      measure(1'b0);
      check("sequence acquire", 16'(lo), (ch == 5'h03) ? 16'h0015 : 16'h0009);
    end
    for (i = 0; i < 4; i++)
    begin
      waitSig(1, 300);
      check("sequence end", {15'h0000, endOfSequence}, {15'h0000, channel == 5'h05});
    end
    xfer(1, adc_timing_pkg::CONFIG1, 16'h0000, 16'h0000);
    // each averaging depth gives one end pulse per set
    for (i = 1; i < 4; i++)
    begin
      xfer(1, adc_timing_pkg::CONFIG0, {2'h0, 2'(i), 12'h003}, 16'h0000);
      waitSig(1, 20000);
      waitSig(1, 20000);
      // count busy falls from one end pulse to the next
      falls = 0;
      @(negedge clk);
      for (lo = 0; lo < 20000 && endOfConversion !== 1'b1; lo++)
      begin
        hi = int'(busy === 1'b1);
        @(negedge clk);
        falls += int'(hi == 1 && busy === 1'b0);
      end
      check("averaged samples", 16'(falls), 16'(16 << (2 * i - 2)));
    end
    stop_test();
  end
endmodule : test_adc_conversion_timing
bind adc_conversion_timing adc_conversion_timing_checker i_adc_conversion_timing_checker
(
  .clk(clk),
  .arst_n(arst_n),
  .portEnable(portEnable),
  .portReady(portReady),
  .busy(busy),
  .endOfConversion(endOfConversion),
  .endOfSequence(endOfSequence),
  .channel(channel)
);
`default_nettype wire
